//--- hdl/opslice_exec.sv
// execution slice: multiplies, negates, complement, no-op, cache block ops
// assumes an apb master on pclk and an operand cache answering on pclk
//
// Summary of operation
// - long multiply writes low product; high kept
// - signed word multiply into low result register
// - unsigned word multiply into low result register
// - negate writes zero minus source, flag kept
// - negate with borrow updates flag to borrow
// - no-op only advances, one state
// - complement writes inverted source in one state
// - invalidate clears valid flag on hit
// - invalidate discards dirty data, no write-back
// - miss or uncached area changes nothing
// - invalidate still reports its four exceptions
// - purge writes dirty line back, then invalidates
// - purge of clean line only invalidates
// - purge reports exceptions except initial page write
`default_nettype none
module opslice_exec
  import opslice_pkg::*;
(
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error, unmapped address
  output logic irq, // level interrupt
  output logic oc_req, // cache lookup request, held to ack
  output logic [31:0] oc_addr, // lookup, write-back, invalidate address
  output logic oc_chk_ipw, // lookup should check initial page write
  input wire logic oc_ack, // lookup answered
  input wire logic oc_hit, // line present and valid
  input wire logic oc_dirty, // line holds unwritten data
  input wire logic oc_cacheable, // address in a cached area
  input wire logic [3:0] oc_exc, // exceptions found by lookup
  output logic wb_req, // write line back, held to ack
  input wire logic wb_ack, // write-back done
  output logic inv // one-cycle pulse: clear valid of line
);
  typedef struct packed {
    logic [15:0][31:0] gpr;
    logic [31:0] mlo;
    logic [31:0] mhi;
    logic t;
    exec_state_t st;
    op_kind_t op;
    logic [2:0] cnt;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [3:0] exc;
    logic [3:0] gsel;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic oc_req;
    logic [31:0] oc_addr;
    logic chk_ipw;
    logic wb_req;
    logic inv;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic acc;
  logic busy;
  logic hold;
  logic issue;
  logic [15:0] ins;
  logic [3:0] n_idx;
  logic [31:0] rm;
  logic [31:0] rn;
  logic [63:0] prod_l;
  logic signed [31:0] prod_s;
  logic [31:0] prod_u;
  logic [31:0] mul_res;
  logic [3:0] exc_m;
  logic [IRQ_W-1:0] ev;
  logic is_nop, is_mull, is_muls, is_mulu;
  logic is_neg, is_negate_with_borrow, is_not, is_block_invalidate_op, is_block_purge_op;

  // decode of the word written to the instruction register
  assign ins = pwdata[15:0];
  assign n_idx = ins[11:8];
  assign rn = s_q.gpr[ins[11:8]];
  assign rm = s_q.gpr[ins[7:4]];
  assign is_nop = ins == NOP_CODE;
  assign is_mull = ins[15:12] == GRP0 && ins[3:0] == FN_MULL;
  assign is_muls = ins[15:12] == GRP2 && ins[3:0] == FN_MULS;
  assign is_mulu = ins[15:12] == GRP2 && ins[3:0] == FN_MULU;
  assign is_neg = ins[15:12] == GRP6 && ins[3:0] == FN_NEG;
  assign is_negate_with_borrow = ins[15:12] == GRP6 && ins[3:0] == FN_NEGATE_WITH_BORROW;
  assign is_not = ins[15:12] == GRP6 && ins[3:0] == FN_NOT;
  assign is_block_invalidate_op = ins[15:12] == GRP0 && ins[7:0] == FN_BLOCK_INVALIDATE_OP;
  assign is_block_purge_op = ins[15:12] == GRP0 && ins[7:0] == FN_BLOCK_PURGE_OP;

  // products from the operands latched at issue
  assign prod_l = s_q.opa * s_q.opb;
  assign prod_s = $signed(s_q.opa[15:0]) * $signed(s_q.opb[15:0]);
  assign prod_u = {16'h0000, s_q.opa[15:0]} * {16'h0000, s_q.opb[15:0]};
  // purge has no initial page write check, so that bit is masked
  assign exc_m = oc_exc & ((s_q.op == K_BLOCK_PURGE_OP) ? EXC_PURGE : EXC_ALL);

  // bus phase tracking; hold stalls pready rather than dropping the access
  assign acc = psel && penable && !s_q.pready;
  assign busy = s_q.st != S_IDLE;
  assign hold = busy && ((pwrite && paddr == A_INSTR) ||
    paddr == A_MRES_LO || paddr == A_MRES_HI);
  assign issue = acc && !hold && pwrite && paddr == A_INSTR;

  always_comb
  begin
    case (s_q.op)
      K_MULL: mul_res = prod_l[31:0];
      K_MULS: mul_res = prod_s;
      K_MULU: mul_res = prod_u;
      default: mul_res = prod_l[31:0];
    endcase
  end

  // one next-state process for the whole block
  always_comb
  begin
    s_d = s_q;
    ev = '0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.inv = 1'b0;
    // register access, answered one cycle into the access phase
    if (acc && !hold)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        A_INSTR, A_IRQ_CLR: ;
        A_STATUS:
        begin
          s_d.prdata[ST_BUSY] = busy;
          s_d.prdata[ST_T] = s_q.t;
          s_d.prdata[ST_EXC_LSB +: 4] = s_q.exc;
        end
        A_GSEL: s_d.prdata[3:0] = s_q.gsel;
        A_GDATA: s_d.prdata = s_q.gpr[s_q.gsel];
        A_MRES_LO: s_d.prdata = s_q.mlo;
        A_MRES_HI: s_d.prdata = s_q.mhi;
        A_FLAG: s_d.prdata[0] = s_q.t;
        A_IRQ_STAT: s_d.prdata[IRQ_W-1:0] = s_q.ist;
        A_IRQ_EN: s_d.prdata[IRQ_W-1:0] = s_q.ien;
        default: s_d.pslverr = 1'b1;
      endcase
      if (pwrite)
      begin
        s_d.prdata = 32'h0000_0000;
        case (paddr)
          A_GSEL: s_d.gsel = pwdata[3:0];
          A_GDATA: s_d.gpr[s_q.gsel] = pwdata;
          A_MRES_LO: s_d.mlo = pwdata;
          A_MRES_HI: s_d.mhi = pwdata;
          A_FLAG: s_d.t = pwdata[0];
          A_IRQ_EN: s_d.ien = pwdata[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
    // instruction issue; single-state operations complete here
    if (issue)
    begin
      s_d.opa = rn;
      s_d.opb = rm;
      s_d.exc = 4'h0;
      s_d.cnt = MUL_CNT_INIT;
      ev[IRQ_DONE] = 1'b1;
      if (is_nop)
        ev[IRQ_DONE] = 1'b1;
      else if (is_mull || is_muls || is_mulu)
      begin
        ev[IRQ_DONE] = 1'b0;
        s_d.st = S_MUL;
        s_d.op = is_mull ? K_MULL : (is_muls ? K_MULS : K_MULU);
      end
      else if (is_neg)
        s_d.gpr[n_idx] = 32'h0000_0000 - rm;
      else if (is_negate_with_borrow)
        {s_d.t, s_d.gpr[n_idx]} =
          33'h0 - {1'b0, rm} - {32'h0, s_q.t};
      else if (is_not)
        s_d.gpr[n_idx] = ~rm;
      else if (is_block_invalidate_op || is_block_purge_op)
      begin
        ev[IRQ_DONE] = 1'b0;
        s_d.st = S_LOOK;
        s_d.op = is_block_invalidate_op ? K_BLOCK_INVALIDATE_OP : K_BLOCK_PURGE_OP;
        s_d.oc_req = 1'b1;
        s_d.oc_addr = rn;
        s_d.chk_ipw = is_block_invalidate_op;
      end
      else
      begin
        ev[IRQ_DONE] = 1'b0;
        ev[IRQ_ILLEGAL] = 1'b1;
      end
    end
    // multi-state execution
    case (s_q.st)
      S_IDLE: ;
      S_MUL:
        if (s_q.cnt == 3'h0)
        begin
          s_d.mlo = mul_res;
          s_d.st = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
        else
          s_d.cnt = s_q.cnt - 3'h1;
      S_LOOK:
        if (oc_ack)
        begin
          s_d.oc_req = 1'b0;
          s_d.exc = exc_m;
          s_d.st = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
          if (exc_m != 4'h0)
            ev[IRQ_EXC] = 1'b1;
          else if (oc_hit && oc_cacheable)
          begin
            // invalidate never writes back, dirty or not
            if (s_q.op == K_BLOCK_PURGE_OP && oc_dirty)
            begin
              s_d.wb_req = 1'b1;
              s_d.st = S_WB;
              ev[IRQ_DONE] = 1'b0;
            end
            else
              s_d.inv = 1'b1;
          end
        end
      S_WB:
        // valid is cleared only once memory holds the line
        if (wb_ack)
        begin
          s_d.wb_req = 1'b0;
          s_d.inv = 1'b1;
          s_d.st = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      default: s_d.st = S_IDLE;
    endcase
    // sticky status: a new event beats a clear in the same cycle
    if (acc && !hold && pwrite && paddr == A_IRQ_CLR)
      s_d.ist = s_q.ist & ~pwdata[IRQ_W-1:0];
    s_d.ist = s_d.ist | ev;
    s_d.irq = |(s_d.ist & s_d.ien);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign oc_req = s_q.oc_req;
  assign oc_addr = s_q.oc_addr;
  assign oc_chk_ipw = s_q.chk_ipw;
  assign wb_req = s_q.wb_req;
  assign inv = s_q.inv;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mul_fin;
  logic look_ok;
  assign mul_fin = s_q.st == S_MUL && s_q.cnt == 3'h0;
  assign look_ok = s_q.st == S_LOOK && oc_ack && exc_m == 4'h0;

  a_mul_span: assert property (
    issue && (is_mull || is_muls || is_mulu) |=>
    (s_q.st == S_MUL)[*3] ##1 s_q.st == S_IDLE)
    else $error("multiply occupancy wrong");
  a_mull_low: assert property (
    mul_fin && s_q.op == K_MULL |=>
    s_q.mlo == $past(prod_l[31:0]) && $stable(s_q.mhi))
    else $error("long multiply result wrong");
  a_muls_prod: assert property (
    mul_fin && s_q.op == K_MULS |=> s_q.mlo ==
    32'($signed($past(s_q.opa[15:0])) * $signed($past(s_q.opb[15:0]))))
    else $error("signed word product wrong");
  a_mulu_prod: assert property (
    mul_fin && s_q.op == K_MULU |=> s_q.mlo ==
    {16'h0000, $past(s_q.opa[15:0])} * {16'h0000, $past(s_q.opb[15:0])})
    else $error("unsigned word product wrong");
  a_neg_result: assert property (
    issue && is_neg |=> s_q.gpr[$past(n_idx)] == 32'h0 - $past(rm)
    && $stable(s_q.t) && s_q.st == S_IDLE)
    else $error("negate result wrong");
  a_negate_with_borrow_borrow: assert property (
    issue && is_negate_with_borrow |=> {s_q.t, s_q.gpr[$past(n_idx)]} ==
    33'h0 - {1'b0, $past(rm)} - {32'h0, $past(s_q.t)})
    else $error("negate with borrow wrong");
  a_nop_quiet: assert property (
    issue && is_nop |=> $stable(s_q.gpr) && s_q.st == S_IDLE)
    else $error("no-op changed state");
  a_not_result: assert property (
    issue && is_not |=> s_q.gpr[$past(n_idx)] == ~$past(rm))
    else $error("complement result wrong");
  a_block_invalidate_op_hit_inv: assert property (
    look_ok && oc_hit && oc_cacheable && s_q.op == K_BLOCK_INVALIDATE_OP |=> inv)
    else $error("invalidate hit did not clear line");
  a_block_invalidate_op_no_wb: assert property (
    s_q.op == K_BLOCK_INVALIDATE_OP |-> !s_q.wb_req)
    else $error("invalidate wrote back");
  a_miss_idle: assert property (
    s_q.st == S_LOOK && oc_ack && !(oc_hit && oc_cacheable) |=>
    !inv && !s_q.wb_req ##1 !inv)
    else $error("cache touched on miss");
  a_block_invalidate_op_exc: assert property (
    s_q.st == S_LOOK && oc_ack && s_q.op == K_BLOCK_INVALIDATE_OP |=>
    s_q.exc == $past(oc_exc) && s_q.ist[IRQ_EXC] == ($past(oc_exc) != 0
    || $past(s_q.ist[IRQ_EXC])))
    else $error("invalidate exception lost");
  a_purge_order: assert property (
    s_q.st == S_WB |-> !inv and (wb_ack |=> inv && !s_q.wb_req))
    else $error("purge order wrong");
  a_clean_purge: assert property (
    look_ok && oc_hit && oc_cacheable && !oc_dirty && s_q.op == K_BLOCK_PURGE_OP
    |=> inv && !s_q.wb_req)
    else $error("clean purge wrote back");
  a_purge_exc: assert property (
    s_q.st == S_LOOK && oc_ack && s_q.op == K_BLOCK_PURGE_OP |=>
    s_q.exc == ($past(oc_exc) & EXC_PURGE) && !s_q.exc[EXC_INIT_PAGE])
    else $error("purge exception wrong");
  a_stall_mlo: assert property (
    psel && penable && paddr == A_MRES_LO && busy |=> !s_q.pready)
    else $error("result read not stalled");
endmodule
`default_nettype wire

//--- hdl/opslice_pkg.sv
// constants for the multiply, negate and cache-block execution slice
// assumes an apb master on pclk and an operand cache on the same clock
`default_nettype none
package opslice_pkg;
  // register byte offsets
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_GSEL = 8'h08;
  localparam logic [7:0] A_GDATA = 8'h0C;
  localparam logic [7:0] A_MRES_LO = 8'h10;
  localparam logic [7:0] A_MRES_HI = 8'h14;
  localparam logic [7:0] A_FLAG = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1C;
  localparam logic [7:0] A_IRQ_CLR = 8'h20;
  localparam logic [7:0] A_IRQ_EN = 8'h24;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_T = 1;
  localparam int ST_EXC_LSB = 4;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_EXC = 1;
  localparam int IRQ_ILLEGAL = 2;
  // exception bits from the address translation side
  localparam int EXC_TLB_MISS = 0;
  localparam int EXC_TLB_PROT = 1;
  localparam int EXC_INIT_PAGE = 2;
  localparam int EXC_ADDR_ERR = 3;
  localparam logic [3:0] EXC_ALL = 4'hF;
  localparam logic [3:0] EXC_PURGE = 4'hB;
  // multiply occupies this many states after issue
  localparam int MUL_STATES = 3;
  localparam logic [2:0] MUL_CNT_INIT = 3'(MUL_STATES - 1);
  // instruction fields
  localparam logic [3:0] GRP0 = 4'h0;
  localparam logic [3:0] GRP2 = 4'h2;
  localparam logic [3:0] GRP6 = 4'h6;
  localparam logic [3:0] FN_MULL = 4'h7;
  localparam logic [3:0] FN_MULS = 4'hF;
  localparam logic [3:0] FN_MULU = 4'hE;
  localparam logic [3:0] FN_NEG = 4'hB;
  localparam logic [3:0] FN_NEGATE_WITH_BORROW = 4'hA;
  localparam logic [3:0] FN_NOT = 4'h7;
  localparam logic [7:0] FN_BLOCK_INVALIDATE_OP = 8'h93;
  localparam logic [7:0] FN_BLOCK_PURGE_OP = 8'hA3;
  localparam logic [15:0] NOP_CODE = 16'h0009;
  typedef enum logic [2:0] {S_IDLE, S_MUL, S_LOOK, S_WB} exec_state_t;
  typedef enum logic [2:0] {K_MULL, K_MULS, K_MULU, K_BLOCK_INVALIDATE_OP, K_BLOCK_PURGE_OP} op_kind_t;
endpackage
`default_nettype wire

//--- verif/cache_mem_model.sv
// behavioural operand cache and external memory facing the execution slice
// assumes the slice on pclk; the bench sets the answer of each lookup
`default_nettype none
module cache_mem_model (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic oc_req, // lookup request from the slice
  input wire logic [31:0] oc_addr, // lookup address
  input wire logic wb_req, // write-back request
  input wire logic inv, // clear valid pulse
  input wire logic slow, // answer after four cycles, not one
  input wire logic w_hit, // line present
  input wire logic w_dirty, // line holds unwritten data
  input wire logic w_cach, // address in a cached area
  input wire logic [3:0] w_exc, // translation faults to report
  output logic oc_ack, // lookup answered
  output logic oc_hit, // hit, valid only with oc_ack
  output logic oc_dirty, // dirty, valid only with oc_ack
  output logic oc_cacheable, // cacheable, valid only with oc_ack
  output logic [3:0] oc_exc, // faults, valid only with oc_ack
  output logic wb_ack, // write-back done
  output logic [31:0] last_addr, // address of the last lookup
  output int wb_count, // line write-backs to memory
  output int inv_count, // lines invalidated
  output int order_errs // invalidations while a write-back pends
);
  logic [2:0] cnt;
  // outside the ack cycle the answer lines carry junk, not the last answer
  assign oc_hit = oc_ack ? w_hit : ~w_hit;
  assign oc_dirty = oc_ack ? w_dirty : ~w_dirty;
  assign oc_cacheable = oc_ack ? w_cach : ~w_cach;
  assign oc_exc = oc_ack ? w_exc : ~w_exc;
  // one request at a time; ack is a single cycle after a set delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {oc_ack, wb_ack, cnt, last_addr} <= '0;
      {wb_count, inv_count, order_errs} <= '0;
    end
    else
    begin
      oc_ack <= 1'b0;
      wb_ack <= 1'b0;
      if ((oc_req && !oc_ack) || (wb_req && !wb_ack))
      begin
        if (cnt == (slow ? 3'h3 : 3'h0))
        begin
          cnt <= 3'h0;
          oc_ack <= oc_req;
          wb_ack <= !oc_req;
          last_addr <= oc_addr;
        end
        else
          cnt <= cnt + 3'h1;
      end
      if (wb_req && wb_ack)
        wb_count <= wb_count + 1;
      if (inv)
        inv_count <= inv_count + 1;
      if (inv && wb_req)
        order_errs <= order_errs + 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/test_opslice_exec.sv
// self-checking bench for the execution slice, apb master and cache model
// assumes the slice answers apb with wait states and one op at a time
`default_nettype none
module test_opslice_exec
  import opslice_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, v, prdata, oc_addr, last_addr;
  logic pready, pslverr, irq, oc_req, oc_chk_ipw, oc_ack, oc_hit, err;
  logic oc_dirty, oc_cacheable, wb_req, wb_ack, inv;
  logic [3:0] oc_exc, w_exc = 4'h0;
  logic slow = 0, w_hit = 0, w_dirty = 0, w_cach = 0;
  int wb_count, inv_count, order_errs, num_errors = 0, comparisons = 0;
  opslice_exec DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .irq, .oc_req, .oc_addr,
    .oc_chk_ipw, .oc_ack, .oc_hit, .oc_dirty, .oc_cacheable, .oc_exc,
    .wb_req, .wb_ack, .inv);
  cache_mem_model model (.pclk, .presetn, .oc_req, .oc_addr, .wb_req,
    .inv, .slow, .w_hit, .w_dirty, .w_cach, .w_exc, .oc_ack, .oc_hit,
    .oc_dirty, .oc_cacheable, .oc_exc, .wb_ack, .last_addr, .wb_count,
    .inv_count, .order_errs);
  always #5 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // access phase of a transfer whose setup already stands on the bus;
  // read data and error land in v and err
  task automatic access_phase;
    int n;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    v = prdata;
    err = pslverr;
    if (n >= 100)
      check(32'h00000000, 32'h00000001);
  endtask
  // one apb transfer with an idle cycle before its setup
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    access_phase;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue an instruction, then set up a read at once with no idle cycle,
  // so that the read meets a multiply still in flight
  task automatic run_read(input logic [15:0] c, input logic [7:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= A_INSTR;
    pwdata <= {16'h0000, c};
    access_phase;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= a;
    access_phase;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setreg(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, A_GSEL, {28'h0000000, i});
    apb(1'b1, A_GDATA, d);
  endtask
  task automatic getreg(input logic [3:0] i);
    apb(1'b1, A_GSEL, {28'h0000000, i});
    apb(1'b0, A_GDATA, 32'h00000000);
  endtask
  task automatic run(input logic [15:0] c);
    apb(1'b1, A_INSTR, {16'h0000, c});
  endtask
  // poll busy with a bound; status is left in v
  task automatic settle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_STATUS, 32'h00000000);
      n++;
    end
    while (v[ST_BUSY] !== 1'b0 && n < 50);
  endtask
  task automatic t_mul;
    setreg(4'h1, 32'hFFFFFFFE);
    setreg(4'h2, 32'h00005555);
    setreg(4'h3, 32'h12348000);
    apb(1'b1, A_MRES_HI, 32'hAAAA0000);
    run_read({GRP0, 4'h1, 4'h2, FN_MULL}, A_MRES_LO); // read must wait
    check(v, 32'hFFFF5556);
    run_read({GRP2, 4'h1, 4'h3, FN_MULS}, A_MRES_LO);
    check(v, 32'h00010000);
    run_read({GRP2, 4'h1, 4'h3, FN_MULU}, A_MRES_LO);
    check(v, 32'h7FFF0000);
    apb(1'b0, A_MRES_HI, 32'h00000000);
    check(v, 32'hAAAA0000);
    $display("multiply test done");
  endtask
  task automatic t_alu;
    logic [31:0] src[4] = '{32'h1, 32'h0, 32'h0, 32'h80000000};
    logic [3:0] tin = 4'b1010;
    logic [32:0] e;
    apb(1'b1, A_FLAG, 32'h00000001);
    setreg(4'h1, 32'h00000001);
    run({GRP6, 4'h2, 4'h1, FN_NEG});
    getreg(4'h2);
    check(v, 32'hFFFFFFFF);
    apb(1'b0, A_FLAG, 32'h00000000);
    check({31'h0, v[0]}, 32'h00000001);
    // borrow cases, including a carry-in with a zero source
    for (int i = 0; i < 4; i++)
    begin
      e = 33'h000000000 - {1'b0, src[i]} - 33'(tin[i]);
      setreg(4'h1, src[i]);
      apb(1'b1, A_FLAG, {31'h0, tin[i]});
      run({GRP6, 4'h3, 4'h1, FN_NEGATE_WITH_BORROW});
      getreg(4'h3);
      check(v, e[31:0]);
      apb(1'b0, A_FLAG, 32'h00000000);
      check({31'h0, v[0]}, {31'h0, e[32]});
    end
    setreg(4'h6, 32'hAAAAAAAA);
    run({GRP6, 4'h7, 4'h6, FN_NOT});
    run(NOP_CODE); // back to back; must not disturb the result
    apb(1'b0, A_STATUS, 32'h00000000);
    check({31'h0, v[ST_BUSY]}, 32'h00000000);
    getreg(4'h7);
    check(v, 32'h55555555);
    $display("negate and complement test done");
  endtask
  task automatic t_cache;
    // purge, slow, hit, dirty, cacheable, faults
    logic [8:0] cs[10] = '{9'b0_0_111_0000, 9'b0_1_011_0000,
      9'b0_0_100_0000, 9'b0_0_111_0100, 9'b0_0_001_0001,
      9'b1_1_111_0000, 9'b1_0_101_0000, 9'b1_0_011_0000,
      9'b1_0_111_0100, 9'b1_0_111_1000};
    logic [3:0] ex;
    logic go;
    logic [31:0] a;
    int wbs, invs;
    for (int i = 0; i < 10; i++)
    begin
      ex = cs[i][3:0] & (cs[i][8] ? EXC_PURGE : EXC_ALL);
      go = (ex == 4'h0) && cs[i][6] && cs[i][4];
      {slow, w_hit, w_dirty, w_cach, w_exc} <= cs[i][7:0];
      a = 32'h00001000 + 32'(i) * 32'h00000020;
      wbs = wb_count;
      invs = inv_count;
      apb(1'b1, A_IRQ_CLR, 32'h00000007);
      setreg(4'h8, a);
      run({GRP0, 4'h8, cs[i][8] ? FN_BLOCK_PURGE_OP : FN_BLOCK_INVALIDATE_OP});
      settle;
      check({28'h0, v[7:4]}, {28'h0, ex});
      check(32'(wb_count - wbs),
        {31'h0, go & cs[i][8] & cs[i][5]});
      check(32'(inv_count - invs), {31'h0, go});
      check(last_addr, a);
      check({31'h0, oc_chk_ipw}, {31'h0, !cs[i][8]});
      apb(1'b0, A_IRQ_STAT, 32'h00000000);
      check({31'h0, v[IRQ_EXC]}, {31'h0, ex != 4'h0});
    end
    check(32'(order_errs), 32'h00000000);
    $display("cache block test done");
  endtask
  task automatic t_irq;
    apb(1'b1, A_IRQ_CLR, 32'h00000007);
    apb(1'b1, A_IRQ_EN, 32'h00000001);
    run(NOP_CODE);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b1, A_IRQ_EN, 32'h00000000);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b0, A_IRQ_STAT, 32'h00000000);
    check(v, 32'h00000001);
    apb(1'b1, A_IRQ_EN, 32'h00000004);
    run(16'hFFFF);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b1, A_IRQ_CLR, 32'h00000007);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    check(v, 32'h00000000);
    $display("interrupt and bus test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence after two cycles of reset
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_mul;
    t_alu;
    t_cache;
    t_irq;
    complete_run;
  end
  // watchdog: tests need well under a thousand cycles, allow 20000
  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
